// ### verilog/shp_host_port.sv
// SRAM-style host port: decode, width and endian steering, data FIFO paths, interrupt pin
`timescale 1ns/1ns
module shp_host_port
    import shp_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [DATA_W-1:0] hostDataIn,
    output logic [DATA_W-1:0] hostDataOut,
    output logic hostDataOe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic chip_select_n,
    input wire logic fifoSelect,
    input wire logic bus_width_strap,
    input wire logic bigEndian,
    input wire logic lowPower,
    output logic wakeUp,
    output logic busWide,
    output shp_csr_req_t csrReq,
    input wire logic [DATA_W-1:0] csrRdData,
    input wire logic [DATA_W-1:0] rxData,
    input wire logic rxValid,
    output logic rxPop,
    output logic [DATA_W-1:0] txData,
    output logic txValid,
    input wire logic txReady,
    output logic txFull,
    output logic txOverflow,
    input wire logic [IRQ_SRC_W-1:0] irqSources,
    input wire logic [IRQ_SRC_W-1:0] irqEnable,
    input wire logic irqPolarity,
    input wire logic irqOpenDrain,
    input wire logic [IVL_W-1:0] irqInterval,
    output logic irqOut,
    output logic irqOe
);
    shp_pins_t pinMeta_q;
    shp_pins_t pinSync_q;
    logic rdAct, wrAct, rdStart, wrEnd, commitNow, txInReady, irqReq;
    logic rdAct_q, wrAct_q, wrFifo_q, wide_q, strapDone_q, wakeUp_q;
    logic [ADDR_W-1:0] wrAddr_q;
    logic [DATA_W-1:0] wrData_q, commitWord, pendWord_q, dataOut_q, csrWord;
    logic [HALF_W-1:0] holdLo_q, holdHi_q;
    logic pendTx_q, txFull_q, txOverflow_q, rxPop_q, dataOe_q;
    logic irqActive_q, irqOut_q, irqOe_q;
    logic [HOLD_W-1:0] holdCycles_q;
    shp_csr_req_t csrReq_q;
    shp_region_t rdRegion, wrRegion;
    shp_rd_state_t st_q;

    // Pins come from an unclocked host; no bus clock exists
    always_ff @(posedge sys_clk) begin
        if (clkEn) begin
            pinMeta_q <= {read_strobe_n, write_strobe_n, chip_select_n, fifoSelect,
                          bus_width_strap, hostAddr, hostDataIn};
            pinSync_q <= pinMeta_q;
        end
    end

    assign rdAct = !pinSync_q.csN && !pinSync_q.rdN;
    assign wrAct = !pinSync_q.csN && !pinSync_q.wrN;
    assign rdStart = rdAct && !rdAct_q;
    assign wrEnd = wrAct_q && !wrAct;
    assign rdRegion = shp_decode(pinSync_q.addr, pinSync_q.fifoSel, 1'b0);
    assign wrRegion = shp_decode(wrAddr_q, wrFifo_q, 1'b1);
    assign commitNow = wrEnd && (wide_q || wrAddr_q[HALF_SEL_BIT]);
    assign commitWord = wide_q ? wrData_q : {wrData_q[HALF_W-1:0], holdLo_q};
    assign csrWord = bigEndian ? shp_swap(csrRdData) : csrRdData;

    // Address and data stay stable around the strobe, so the last active sample is used
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdAct_q <= 1'b0;
            wrAct_q <= 1'b0;
            wrAddr_q <= '0;
            wrData_q <= '0;
            wrFifo_q <= 1'b0;
        end else if (clkEn) begin
            rdAct_q <= rdAct;
            wrAct_q <= wrAct;
            if (wrAct) begin
                wrAddr_q <= pinSync_q.addr;
                wrData_q <= pinSync_q.data;
                wrFifo_q <= pinSync_q.fifoSel;
            end
        end
    end

    // Strap is sampled on the first enabled cycle after release
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wide_q <= WIDE_RST;
            strapDone_q <= 1'b0;
        end else if (clkEn && !strapDone_q) begin
            wide_q <= pinSync_q.strap;
            strapDone_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wakeUp_q <= 1'b0;
        end else if (clkEn) begin
            wakeUp_q <= lowPower && wrAct && !wrAct_q;
        end
    end

    // Control register requests; a write ending wins the address over a read start
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            csrReq_q <= '0;
            holdLo_q <= '0;
        end else if (clkEn) begin
            csrReq_q.we <= 1'b0;
            csrReq_q.re <= 1'b0;
            if (rdStart && rdRegion == RG_CSR && (wide_q || !pinSync_q.addr[HALF_SEL_BIT])) begin
                csrReq_q.re <= 1'b1;
                csrReq_q.addr <= pinSync_q.addr[ADDR_W-1:HALF_SEL_BIT+1];
            end
            if (wrEnd && !wide_q && !wrAddr_q[HALF_SEL_BIT]) begin
                holdLo_q <= wrData_q[HALF_W-1:0];
            end
            if (commitNow && wrRegion == RG_CSR) begin
                csrReq_q.we <= 1'b1;
                csrReq_q.addr <= wrAddr_q[ADDR_W-1:HALF_SEL_BIT+1];
                csrReq_q.wdata <= bigEndian ? shp_swap(commitWord) : commitWord;
            end
        end
    end

    // One word waits here while the FIFO is full; a second one overruns it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pendTx_q <= 1'b0;
            pendWord_q <= '0;
            txOverflow_q <= 1'b0;
            txFull_q <= 1'b0;
        end else if (clkEn) begin
            txFull_q <= !txInReady;
            if (commitNow && wrRegion == RG_TX) begin
                pendTx_q <= 1'b1;
                pendWord_q <= commitWord;
                if (pendTx_q && !txInReady) begin
                    txOverflow_q <= 1'b1;
                end
            end else if (pendTx_q && txInReady) begin
                pendTx_q <= 1'b0;
            end
        end
    end

    // Read side: fetch a word, drive it until the strobe goes away
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            dataOut_q <= '0;
            dataOe_q <= 1'b0;
            holdHi_q <= '0;
            rxPop_q <= 1'b0;
        end else if (clkEn) begin
            rxPop_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (rdStart) begin
                        st_q <= ST_DRIVE;
                        dataOe_q <= 1'b1;
                        if (!wide_q && pinSync_q.addr[HALF_SEL_BIT]) begin
                            dataOut_q <= {{HALF_W{1'b0}}, holdHi_q};
                        end else if (rdRegion == RG_CSR) begin
                            st_q <= ST_CSR;
                            dataOe_q <= 1'b0;
                        end else if (rdRegion == RG_RX && rxValid) begin
                            rxPop_q <= 1'b1;
                            holdHi_q <= rxData[DATA_W-1:HALF_W];
                            dataOut_q <= wide_q ? rxData : {{HALF_W{1'b0}}, rxData[HALF_W-1:0]};
                        end else begin
                            dataOut_q <= '0;
                        end
                    end
                end
                ST_CSR: begin
                    if (!rdAct) begin
                        st_q <= ST_IDLE;
                    end else begin
                        st_q <= ST_DRIVE;
                        dataOe_q <= 1'b1;
                        if (wide_q) begin
                            dataOut_q <= csrWord;
                        end else begin
                            holdHi_q <= csrWord[DATA_W-1:HALF_W];
                            dataOut_q <= {{HALF_W{1'b0}}, csrWord[HALF_W-1:0]};
                        end
                    end
                end
                ST_DRIVE: begin
                    if (!rdAct) begin
                        st_q <= ST_IDLE;
                        dataOe_q <= 1'b0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                    dataOe_q <= 1'b0;
                end
            endcase
        end
    end

    // Interrupt: a clear starts the hold-off, during which nothing re-asserts
    assign irqReq = |(irqSources & irqEnable);
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irqActive_q <= 1'b0;
            holdCycles_q <= '0;
        end else if (clkEn) begin
            if (holdCycles_q != '0) begin
                holdCycles_q <= holdCycles_q - 1'b1;
            end else if (irqActive_q && !irqReq) begin
                irqActive_q <= 1'b0;
                holdCycles_q <= HOLD_W'(int'(irqInterval) * IRQ_TICK_CYC);
            end else if (!irqActive_q && irqReq) begin
                irqActive_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irqOut_q <= 1'b0;
            irqOe_q <= 1'b0;
        end else if (clkEn) begin
            irqOut_q <= irqOpenDrain ? 1'b0 : (irqActive_q ~^ irqPolarity);
            irqOe_q <= irqOpenDrain ? irqActive_q : 1'b1;
        end
    end

    shp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txFifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inValid(pendTx_q),
        .inData(pendWord_q),
        .inReady(txInReady),
        .outValid(txValid),
        .outData(txData),
        .outReady(txReady)
    );

    assign hostDataOut = dataOut_q;
    assign hostDataOe = dataOe_q;
    assign wakeUp = wakeUp_q;
    assign busWide = wide_q;
    assign csrReq = csrReq_q;
    assign rxPop = rxPop_q;
    assign txFull = txFull_q;
    assign txOverflow = txOverflow_q;
    assign irqOut = irqOut_q;
    assign irqOe = irqOe_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_decode;
        clkEn && rdStart && !wrEnd && rdRegion == RG_CSR && wide_q
            |=> csrReq_q.re && csrReq_q.addr == $past(pinSync_q.addr[ADDR_W-1:HALF_SEL_BIT+1]);
    endproperty
    a_decode: assert property (p_decode) else $error("csr read not decoded");
    property p_no_cs;
        clkEn && !rdAct && !wrAct && !wrAct_q |=> !csrReq_q.we && !csrReq_q.re;
    endproperty
    a_no_cs: assert property (p_no_cs) else $error("access without select");
    property p_wake;
        clkEn && lowPower && wrAct && !wrAct_q |=> wakeUp_q;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed");
    property p_fifo_sel;
        clkEn && wrEnd && wrFifo_q && wide_q |=> pendTx_q && !csrReq_q.we;
    endproperty
    a_fifo_sel: assert property (p_fifo_sel) else $error("fifo select not honoured");
    property p_wide_wr;
        clkEn && wrEnd && wide_q && wrRegion == RG_CSR && !bigEndian
            |=> csrReq_q.we && csrReq_q.wdata == $past(wrData_q);
    endproperty
    a_wide_wr: assert property (p_wide_wr) else $error("32-bit write wrong");
    property p_half_join;
        clkEn && commitNow && !wide_q && wrRegion == RG_CSR && !bigEndian
            |=> csrReq_q.wdata == {$past(wrData_q[HALF_W-1:0]), $past(holdLo_q)};
    endproperty
    a_half_join: assert property (p_half_join) else $error("halves joined wrong");
    property p_swap;
        clkEn && commitNow && wide_q && wrRegion == RG_CSR && bigEndian
            |=> csrReq_q.wdata == shp_swap($past(wrData_q));
    endproperty
    a_swap: assert property (p_swap) else $error("byte swap wrong");
    property p_release;
        dataOe_q && clkEn && !rdAct |=> !dataOe_q;
    endproperty
    a_release: assert property (p_release) else $error("bus driven after strobe");
    property p_irq_pin;
        clkEn && !irqOpenDrain
            |=> irqOe_q && irqOut_q == ($past(irqActive_q) ~^ $past(irqPolarity));
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq pin level wrong");
    property p_holdoff;
        holdCycles_q != '0 |-> !irqActive_q;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("irq during hold-off");
    property p_strap;
        clkEn && !strapDone_q |=> strapDone_q && wide_q == $past(pinSync_q.strap);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");
    property p_half_wait;
        clkEn && wrEnd && !wide_q && !wrAddr_q[HALF_SEL_BIT]
            |=> !csrReq_q.we && holdLo_q == $past(wrData_q[HALF_W-1:0]);
    endproperty
    a_half_wait: assert property (p_half_wait) else $error("half write committed");

    c_csr_read: cover property (st_q == ST_CSR ##1 st_q == ST_DRIVE);
    c_tx_full: cover property (txFull_q && pendTx_q);
    c_holdoff: cover property ($fell(irqActive_q) ##1 holdCycles_q != '0);
    c_half_write: cover property (commitNow && !wide_q);
endmodule

// ### verilog/shp_pkg.sv
// Shared constants, types and helpers for the SRAM-style host port
package shp_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int CSR_IDX_W = 6;
    localparam int PORT_LSB = 2;
    localparam int PORT_W = 5;
    localparam int HALF_SEL_BIT = 0;
    localparam logic [PORT_W-1:0] RX_PORT_IDX = 5'h00;
    localparam logic [PORT_W-1:0] TX_PORT_IDX = 5'h01;
    localparam int IRQ_SRC_W = 8;
    localparam int IVL_W = 8;
    localparam int HOLD_W = 20;
    localparam int CLK_PERIOD_NS = 20;
    // Hold-off interval unit
    localparam int IRQ_TICK_NS = 10000;
    localparam int IRQ_TICK_CYC = (IRQ_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TX_FIFO_DEPTH = 32;
    localparam logic WIDE_RST = 1'b1;

    typedef enum logic [1:0] {RG_CSR, RG_RX, RG_TX, RG_NONE} shp_region_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CSR, ST_DRIVE} shp_rd_state_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [CSR_IDX_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } shp_csr_req_t;

    typedef struct packed {
        logic rdN;
        logic wrN;
        logic csN;
        logic fifoSel;
        logic strap;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } shp_pins_t;

    function automatic shp_region_t shp_decode(input logic [ADDR_W-1:0] a,
                                               input logic fsel, input logic isWrite);
        shp_region_t r;
        r = RG_CSR;
        if (fsel) begin
            r = isWrite ? RG_TX : RG_RX;
        end else if (a[ADDR_W-1:PORT_LSB] == RX_PORT_IDX) begin
            r = isWrite ? RG_NONE : RG_RX;
        end else if (a[ADDR_W-1:PORT_LSB] == TX_PORT_IDX) begin
            r = isWrite ? RG_TX : RG_NONE;
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] shp_swap(input logic [DATA_W-1:0] w);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W / BYTE_W; i++) begin
            r[i*BYTE_W +: BYTE_W] = w[(DATA_W/BYTE_W-1-i)*BYTE_W +: BYTE_W];
        end
        return r;
    endfunction
endpackage

// ### verilog/shp_fifo.sv
// Transmit data FIFO with registered output stage
`timescale 1ns/1ns
module shp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic outValid_q;
    logic [WIDTH-1:0] outData_q;
    logic push;
    logic load;

    assign inReady = (count_q != FULL_CNT);
    assign push = inValid && inReady;
    // Refill the output stage whenever it is empty or being taken
    assign load = (count_q != '0) && (!outValid_q || outReady);
    assign outValid = outValid_q;
    assign outData = outData_q;

    always_ff @(posedge sys_clk) begin
        if (clkEn && push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (clkEn) begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
            end
            if (load) begin
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
            end
            if (push && !load) begin
                count_q <= count_q + 1'b1;
            end else if (load && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else if (clkEn) begin
            if (load) begin
                outValid_q <= 1'b1;
                outData_q <= mem[rdPtr_q];
            end else if (outReady) begin
                outValid_q <= 1'b0;
            end
        end
    end
endmodule

// ### verification/shp_host_model.sv
// Host processor model driving the SRAM-style bus pins
`timescale 1ns/1ns
module shp_host_model
    import shp_pkg::*;
(
    input wire logic sys_clk,
    output logic [ADDR_W-1:0] hostAddr,
    output logic [DATA_W-1:0] hostDataIn,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic chip_select_n,
    output logic fifoSelect,
    input wire logic [DATA_W-1:0] hostDataOut
);
    initial begin
        hostAddr = '0;
        hostDataIn = 32'h5a5a_c3c3;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        fifoSelect = 1'b0;
    end

    // Strobe low 6 cycles, high 6: the synchroniser needs at least 3 of each
    task automatic access(input logic wr, input logic cs, input logic fsel,
                          input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] rd);
        @(negedge sys_clk);
        hostAddr = a;
        fifoSelect = fsel;
        hostDataIn = wr ? d : ~hostDataIn;
        chip_select_n = !cs;
        read_strobe_n = wr;
        write_strobe_n = !wr;
        // Sample read data away from the edge that updates it
        repeat (6) @(negedge sys_clk);
        rd = hostDataOut;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        // Released bus has no pull: show a changed level, not the old data
        hostDataIn = ~hostDataIn;
        repeat (6) @(negedge sys_clk);
    endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the SRAM-style host port
`timescale 1ns/1ns
module tb_top;
    import shp_pkg::*;
    logic sys_clk, rst_n, bus_width_strap, bigEndian, lowPower, rxValid, txReady;
    logic irqPolarity, irqOpenDrain, read_strobe_n, write_strobe_n, chip_select_n;
    logic fifoSelect, hostDataOe, wakeUp, busWide, rxPop, txValid, txFull, txOverflow;
    logic irqOut, irqOe;
    logic [IRQ_SRC_W-1:0] irqSources, irqEnable;
    logic [IVL_W-1:0] irqInterval;
    logic [ADDR_W-1:0] hostAddr, a;
    logic [DATA_W-1:0] hostDataIn, hostDataOut, csrRdData, txData, rxWord, rd, d, rnd;
    shp_csr_req_t csrReq;
    logic [37:0] weQ[$];
    logic [31:0] txQ[$], expQ[$];
    int nFail, checked, wakeCnt, oeCnt, popCnt, reCnt;

    function automatic logic [31:0] nextRnd();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    function automatic logic [31:0] csrVal(input logic [5:0] x);
        return {2'b10, x, 2'b01, x, 2'b11, x, 2'b00, x};
    endfunction

    assign csrRdData = csrVal(csrReq.addr);

    always #10 sys_clk = ~sys_clk;

    shp_host_model host (.sys_clk(sys_clk), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chip_select_n(chip_select_n), .fifoSelect(fifoSelect), .hostDataOut(hostDataOut));

    // Small FIFO keeps the fill-until-full run short
    shp_host_port #(.FIFO_DEPTH(4)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1),
        .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
        .fifoSelect(fifoSelect), .bus_width_strap(bus_width_strap), .bigEndian(bigEndian),
        .lowPower(lowPower), .wakeUp(wakeUp), .busWide(busWide), .csrReq(csrReq),
        .csrRdData(csrRdData), .rxData(rxWord), .rxValid(rxValid), .rxPop(rxPop),
        .txData(txData), .txValid(txValid), .txReady(txReady), .txFull(txFull),
        .txOverflow(txOverflow), .irqSources(irqSources), .irqEnable(irqEnable),
        .irqPolarity(irqPolarity), .irqOpenDrain(irqOpenDrain), .irqInterval(irqInterval),
        .irqOut(irqOut), .irqOe(irqOe));

    always @(posedge sys_clk) begin
        if (csrReq.we === 1'b1) weQ.push_back({csrReq.addr, csrReq.wdata});
        if (txValid === 1'b1 && txReady) txQ.push_back(txData);
        if (wakeUp === 1'b1) wakeCnt++;
        if (csrReq.re === 1'b1) reCnt++;
        if (hostDataOe === 1'b1) oeCnt++;
        if (rxPop === 1'b1) begin
            popCnt++;
            rxWord <= {rxWord[15:0], ~rxWord[31:16]};
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            nFail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic expWe(input logic [5:0] x, input logic [31:0] v);
        logic [37:0] e;
        chk(32'(weQ.size()), 1, "write count");
        e = (weQ.size() > 0) ? weQ.pop_front() : '0;
        chk(e[31:0], v, "write data");
        chk(32'(e[37:32]), 32'(x), "write index");
        weQ.delete();
    endtask

    task automatic doReset(input logic s);
        @(negedge sys_clk);
        rst_n = 1'b0;
        bus_width_strap = s;
        repeat (10) @(negedge sys_clk);
        chk(32'(busWide), 1, "width in reset");
        rst_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk(32'(busWide), 32'(s), "latched width");
        weQ.delete();
        txQ.delete();
    endtask

    task automatic irqSet(input logic [7:0] s, input int n);
        @(negedge sys_clk);
        irqSources = s;
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic print_verdict();
        if (nFail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        nFail++;
        print_verdict();
    end

    initial begin
        sys_clk = 0;
        rst_n = 0;
        bus_width_strap = 1;
        {bigEndian, lowPower, irqOpenDrain} = '0;
        {rxValid, txReady, irqPolarity} = '1;
        {irqSources, irqEnable, irqInterval} = '0;
        rnd = 32'hfc779365;
        rxWord = 32'h1234abcd;
        doReset(1'b1);
        // Random CSR traffic, with the lowest and highest CSR index first
        for (int i = 0; i < 8; i++) begin
            d = nextRnd();
            a = (i == 0) ? 7'h7e : (i == 1) ? 7'h08 : {5'(2 + d[31:27] % 30), d[1], 1'b0};
            d = nextRnd();
            host.access(1, 1, 0, a, d, rd);
            expWe(a[6:1], d);
            host.access(0, 1, 0, a, '0, rd);
            chk(rd, csrVal(a[6:1]), "csr read");
        end
        chk(32'(reCnt), 8, "csr reads");
        wakeCnt = 0;
        oeCnt = 0;
        reCnt = 0;
        lowPower = 1;
        host.access(1, 0, 0, 7'h20, d, rd);
        host.access(0, 0, 0, 7'h20, d, rd);
        chk(32'(weQ.size() + wakeCnt + oeCnt + reCnt), 0, "unselected");
        host.access(1, 1, 0, 7'h20, d, rd);
        chk(32'(wakeCnt), 1, "wake");
        expWe(6'h10, d);
        lowPower = 0;
        bigEndian = 1;
        host.access(1, 1, 0, 7'h30, d, rd);
        expWe(6'h18, {d[7:0], d[15:8], d[23:16], d[31:24]});
        host.access(0, 1, 0, 7'h30, '0, rd);
        d = csrVal(6'h18);
        chk(rd, {d[7:0], d[15:8], d[23:16], d[31:24]}, "be read");
        bigEndian = 0;
        // FIFO select ignores the upper address; default map uses ports 0 and 1
        host.access(1, 1, 1, 7'h7c, d, rd);
        host.access(1, 1, 0, 7'h04, ~d, rd);
        host.access(1, 1, 0, 7'h00, 32'h0bad_0bad, rd);
        chk(32'(weQ.size() + txQ.size()), 2, "tx count");
        chk(txQ.pop_front(), d, "tx fsel");
        chk(txQ.pop_front(), ~d, "tx port");
        for (int i = 0; i < 2; i++) begin
            d = rxWord;
            host.access(0, 1, i[0], i[0] ? 7'h7d : 7'h00, '0, rd);
            chk(rd, d, "rx read");
            chk(32'(popCnt), 32'(i + 1), "rx pop");
        end
        host.access(0, 1, 0, 7'h04, '0, rd);
        chk(rd, 0, "tx port read");
        // Fill the transmit path until full while the far side stalls
        txReady = 0;
        expQ.delete();
        for (int i = 0; i < 5; i++) begin
            expQ.push_back(nextRnd());
            host.access(1, 1, 1, 7'h00, expQ[i], rd);
        end
        chk(32'(txFull), 1, "full");
        txReady = 1;
        repeat (20) @(negedge sys_clk);
        chk(32'(txFull) + 32'(txOverflow), 0, "drained");
        chk(32'(txQ.size()), 5, "drain count");
        foreach (expQ[i]) chk(txQ.size() > i ? txQ[i] : '0, expQ[i], "drain order");
        // Two words beyond what the path holds: the waiting one is overrun
        txReady = 0;
        for (int i = 0; i < 7; i++) host.access(1, 1, 1, 7'h00, nextRnd(), rd);
        chk(32'(txOverflow), 1, "overflow");
        txReady = 1;
        // Interrupt pin in every polarity and buffer type
        irqEnable = 8'h0f;
        for (int m = 0; m < 4; m++) begin
            irqPolarity = m[0];
            irqOpenDrain = m[1];
            irqSet(8'h14, 4);
            chk({irqOut, irqOe}, {!m[1] & m[0], 1'b1}, "irq on");
            irqSet(8'h10, 4);
            chk({irqOut, irqOe}, {!m[1] & !m[0], !m[1]}, "irq off");
        end
        irqPolarity = 1;
        irqOpenDrain = 0;
        irqInterval = 8'h01;
        irqSet(8'h04, 4);
        chk(32'(irqOut), 1, "irq set");
        irqSet(8'h00, 4);
        irqSet(8'h04, 400);
        chk(32'(irqOut), 0, "hold off");
        repeat (150) @(negedge sys_clk);
        chk(32'(irqOut), 1, "after hold off");
        // Narrow bus: halves join into one word and split on read
        doReset(1'b0);
        d = nextRnd();
        host.access(1, 1, 0, 7'h14, {16'hdead, d[15:0]}, rd);
        chk(32'(weQ.size()), 0, "half pending");
        host.access(1, 1, 0, 7'h15, {16'hbeef, d[31:16]}, rd);
        expWe(6'h0a, d);
        host.access(0, 1, 0, 7'h14, '0, rd);
        chk(32'(rd[15:0]), 32'(csrVal(6'h0a) & 32'hffff), "low half");
        host.access(0, 1, 0, 7'h15, '0, rd);
        chk(32'(rd[15:0]), 32'(csrVal(6'h0a) >> 16), "high half");
        print_verdict();
    end
endmodule
